// [logic/uart_baud_frame_core.sv]
// UART core: baud generator, transmitter, receiver, Wishbone registers.
// Assumes one 20 MHz clock, synchronous rxd_i, classic Wishbone master.
//
// The Wishbone interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module uart_baud_frame_core (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rxd_i,
  output logic txd_o,
  output logic txd_oe_o
);
  import uart_pkg::*;

  // -------------------------------------------------------------
  // State
  // -------------------------------------------------------------
  typedef struct packed {
    logic [11:0] div; // Baud divisor
    logic [11:0] cnt; // Baud down-counter
    logic tick; // Baud tick
    logic u2x; // Double speed
    logic [2:0] csz; // Character size code
    logic [1:0] upm; // Parity mode
    logic usbs; // Two stop bits
    logic rxen; // Receiver on
    logic transmitter_enable_bit; // Transmitter on
    logic tx9; // Ninth bit to send
    logic prr; // Power reduce
    logic ack; // Bus answer
    logic [7:0] rdat; // Read data
    tx_state_t tx_st; // Transmit state
    logic [3:0] tx_sub; // Ticks within bit
    logic [3:0] tx_bit; // Bit index
    logic [8:0] tx_sh; // Transmit shifter
    logic tx_par; // Parity to send
    logic [8:0] tx_buf; // Write buffer
    logic udre; // Buffer empty
    logic txc; // Transmit complete
    logic txd; // Line level
    logic txoe; // Pin override
    rx_state_t rx_st; // Receive state
    logic [3:0] rx_sub; // Ticks within bit
    logic [3:0] rx_bit; // Bit index
    logic [8:0] rx_sh; // Receive shifter
    logic rx_par; // Running parity
    logic perr; // Parity mismatch
    logic [1:0] vote; // Early samples
    logic rx_prev; // Line at last tick
    logic [1:0][10:0] rx_q; // Entries {pe,fe,data}
    logic rx_hd; // Head index
    logic [1:0] rx_cnt; // Entries held
    logic dor; // Overrun
  } state_t;

  state_t st_r; // Registered state
  state_t st_nxt; // Next state

  // -------------------------------------------------------------
  // Decode helpers
  // -------------------------------------------------------------
  logic acc, wr, pop, wr_bdl;
  logic [4:0] ovs;
  logic [3:0] last, mid, nbits;
  logic [8:0] dmask, rx_word;
  logic maj, rx_on, rx_dec, rx_push, tx_end, tx_load;
  logic [10:0] hd_e;
  logic [7:0] rd_val;

  assign acc = wb_cyc_i & wb_stb_i;
  assign wr = acc & st_r.ack & wb_we_i & wb_sel_i[0];
  assign pop = acc & st_r.ack & ~wb_we_i & (wb_adr_i == ADR_DATA);
  assign wr_bdl = wr & (wb_adr_i == ADR_BDL);
  assign ovs = st_r.u2x ? OVS_DBL : OVS_NORM;
  assign last = 4'(ovs - 5'h01);
  assign mid = 4'(ovs >> 1);
  // Data bit count; reserved codes act as eight
  assign nbits = (st_r.csz == CSZ_NINE) ? 4'h9 : st_r.csz[2] ? 4'h8 :
    4'h5 + {2'h0, st_r.csz[1:0]};
  assign dmask = 9'h1ff >> (4'h9 - nbits);
  assign rx_word = st_r.rx_sh >> (4'h9 - nbits);
  // Two earlier samples plus the present one
  assign maj = (st_r.vote[0] & st_r.vote[1]) | (st_r.vote[0] & rxd_i) |
    (st_r.vote[1] & rxd_i);
  assign rx_on = st_r.rxen & ~st_r.prr;
  assign rx_dec = rx_on & st_r.tick & (st_r.rx_st != RX_IDLE) &
    (st_r.rx_sub == mid + 4'h1);
  assign rx_push = rx_dec & (st_r.rx_st == RX_STOP);
  assign tx_end = st_r.tick & (st_r.tx_st == TX_STOP) &
    (st_r.tx_sub == last) & ~(st_r.usbs & (st_r.tx_bit == 4'h0));
  // Pending data still goes out after disable
  assign tx_load = ~st_r.udre & (st_r.transmitter_enable_bit | st_r.txoe);
  assign hd_e = st_r.rx_q[st_r.rx_hd];

  // -------------------------------------------------------------
  // Read mux
  // -------------------------------------------------------------
  always_comb begin
    rd_val = 8'h00;
    case (wb_adr_i)
      ADR_DATA: rd_val = hd_e[7:0];
      ADR_CSA: begin
        rd_val[CSA_RXC] = st_r.rx_cnt != 2'h0;
        rd_val[CSA_TXC] = st_r.txc;
        rd_val[CSA_UDRE] = st_r.udre;
        rd_val[CSA_FERR] = hd_e[9] & (st_r.rx_cnt != 2'h0);
        rd_val[CSA_DOR] = st_r.dor;
        rd_val[CSA_PERR] = hd_e[10] & (st_r.rx_cnt != 2'h0);
        rd_val[CSA_U2X] = st_r.u2x;
      end
      ADR_CSB: begin
        rd_val[CSB_RXEN] = st_r.rxen;
        rd_val[CSB_TRANSMITTER_ENABLE_BIT] = st_r.transmitter_enable_bit;
        rd_val[CSB_CSZ2] = st_r.csz[2];
        rd_val[CSB_RX9] = hd_e[8];
        rd_val[CSB_TX9] = st_r.tx9;
      end
      ADR_CSC: begin
        rd_val[CSC_PM +: 2] = st_r.upm;
        rd_val[CSC_STOP] = st_r.usbs;
        rd_val[CSC_CSZ +: 2] = st_r.csz[1:0];
      end
      ADR_BDL: rd_val = st_r.div[7:0];
      ADR_BDH: rd_val = {4'h0, st_r.div[11:8]};
      ADR_PRR: rd_val[PRR_BIT] = st_r.prr;
      default: rd_val = 8'h00; // Unmapped reads zero
    endcase
  end

  // -------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // Answer one cycle after request, for one cycle
    st_nxt.ack = acc & ~st_r.ack;
    if (acc & ~st_r.ack) begin
      st_nxt.rdat = rd_val;
    end
    // Register writes; take effect at the acknowledged edge
    if (wr) begin
      case (wb_adr_i)
        ADR_CSA: begin
          st_nxt.u2x = wb_dat_i[CSA_U2X];
          if (wb_dat_i[CSA_TXC]) begin
            st_nxt.txc = 1'b0;
          end
        end
        ADR_CSB: begin
          st_nxt.rxen = wb_dat_i[CSB_RXEN];
          st_nxt.transmitter_enable_bit = wb_dat_i[CSB_TRANSMITTER_ENABLE_BIT];
          st_nxt.csz[2] = wb_dat_i[CSB_CSZ2];
          st_nxt.tx9 = wb_dat_i[CSB_TX9];
        end
        ADR_CSC: begin
          st_nxt.upm = wb_dat_i[CSC_PM +: 2];
          st_nxt.usbs = wb_dat_i[CSC_STOP];
          st_nxt.csz[1:0] = wb_dat_i[CSC_CSZ +: 2];
        end
        ADR_BDL: st_nxt.div[7:0] = wb_dat_i[7:0];
        ADR_BDH: st_nxt.div[11:8] = wb_dat_i[3:0];
        ADR_PRR: st_nxt.prr = wb_dat_i[PRR_BIT];
        default: ; // Unmapped writes ignored
      endcase
    end
    // Baud generator
    if (st_r.cnt == 12'h000 || wr_bdl) begin
      st_nxt.cnt = st_nxt.div;
    end else begin
      st_nxt.cnt = st_r.cnt - 12'h001;
    end
    st_nxt.tick = (st_r.cnt == 12'h000) & ~st_r.prr;
    // Reading data drops the head entry
    if (pop && st_r.rx_cnt != 2'h0) begin
      st_nxt.rx_hd = ~st_r.rx_hd;
      st_nxt.rx_cnt = st_r.rx_cnt - 2'h1;
      st_nxt.dor = 1'b0;
    end
    // Transmitter bit timing
    if (st_r.tx_st != TX_IDLE && st_r.tick) begin
      st_nxt.tx_sub = st_r.tx_sub + 4'h1;
      if (st_r.tx_sub == last) begin
        st_nxt.tx_sub = 4'h0;
        case (st_r.tx_st)
          TX_START: begin
            st_nxt.tx_st = TX_DATA;
            st_nxt.tx_bit = 4'h0;
          end
          TX_DATA: begin
            st_nxt.tx_sh = st_r.tx_sh >> 1; // LSB first
            st_nxt.tx_bit = st_r.tx_bit + 4'h1;
            if (st_r.tx_bit == nbits - 4'h1) begin
              st_nxt.tx_st = st_r.upm[1] ? TX_PAR : TX_STOP;
              st_nxt.tx_bit = 4'h0;
            end
          end
          TX_PAR: st_nxt.tx_st = TX_STOP;
          default: st_nxt.tx_bit = 4'h1; // Second stop bit
        endcase
      end
    end
    // Load shifter when idle or right after the last stop
    if ((st_r.tx_st == TX_IDLE || tx_end) && tx_load) begin
      st_nxt.tx_st = TX_START;
      st_nxt.tx_sub = 4'h0;
      st_nxt.tx_sh = st_r.tx_buf & dmask;
      st_nxt.tx_par = ^(st_r.tx_buf & dmask) ^ st_r.upm[0];
      st_nxt.udre = 1'b1;
    end else if (tx_end) begin
      st_nxt.tx_st = TX_IDLE;
      st_nxt.txc = 1'b1;
    end
    // Receiver
    if (!rx_on) begin
      st_nxt.rx_st = RX_IDLE;
      st_nxt.rx_prev = 1'b1;
    end else if (st_r.tick) begin
      st_nxt.rx_prev = rxd_i;
      if (st_r.rx_st == RX_IDLE) begin
        // Falling edge is a candidate start bit
        if (st_r.rx_prev && !rxd_i) begin
          st_nxt.rx_st = RX_START;
          st_nxt.rx_sub = 4'h1;
        end
      end else begin
        st_nxt.rx_sub = st_r.rx_sub + 4'h1;
        if (st_r.rx_sub == mid - 4'h1) begin
          st_nxt.vote[0] = rxd_i;
        end
        if (st_r.rx_sub == mid) begin
          st_nxt.vote[1] = rxd_i;
        end
        if (rx_dec) begin
          case (st_r.rx_st)
            RX_START: begin
              if (maj) begin
                st_nxt.rx_st = RX_IDLE;
              end
            end
            RX_DATA: begin
              st_nxt.rx_sh = {maj, st_r.rx_sh[8:1]};
              st_nxt.rx_par = st_r.rx_par ^ maj;
            end
            RX_PAR: st_nxt.perr = maj ^ st_r.rx_par ^ st_r.upm[0];
            default: st_nxt.rx_st = RX_IDLE;
          endcase
        end
        if (st_r.rx_sub == last) begin
          st_nxt.rx_sub = 4'h0;
          case (st_r.rx_st)
            RX_START: begin
              st_nxt.rx_st = RX_DATA;
              st_nxt.rx_bit = 4'h0;
              st_nxt.rx_par = 1'b0;
              st_nxt.perr = 1'b0;
            end
            RX_DATA: begin
              st_nxt.rx_bit = st_r.rx_bit + 4'h1;
              if (st_r.rx_bit == nbits - 4'h1) begin
                st_nxt.rx_st = st_r.upm[1] ? RX_PAR : RX_STOP;
              end
            end
            RX_PAR: st_nxt.rx_st = RX_STOP;
            default: ;
          endcase
        end
      end
    end
    // Store frame; a full buffer loses it and flags overrun
    if (rx_push) begin
      if (st_nxt.rx_cnt == 2'h2) begin
        st_nxt.dor = 1'b1;
      end else begin
        st_nxt.rx_q[st_nxt.rx_hd ^ st_nxt.rx_cnt[0]] =
          {st_r.perr & st_r.upm[1], ~maj, rx_word};
        st_nxt.rx_cnt = st_nxt.rx_cnt + 2'h1;
      end
    end
    // Data write fills the buffer
    if (wr && wb_adr_i == ADR_DATA) begin
      st_nxt.tx_buf = {st_r.tx9, wb_dat_i[7:0]};
      st_nxt.udre = 1'b0;
    end
    // Pin override held until all data has gone
    st_nxt.txoe = st_nxt.transmitter_enable_bit | (st_nxt.tx_st != TX_IDLE) |
      ~st_nxt.udre;
    case (st_nxt.tx_st)
      TX_START: st_nxt.txd = 1'b0;
      TX_DATA: st_nxt.txd = st_nxt.tx_sh[0];
      TX_PAR: st_nxt.txd = st_nxt.tx_par;
      default: st_nxt.txd = 1'b1; // Stop and idle high
    endcase
  end

  // -------------------------------------------------------------
  // State register
  // -------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
      st_r.csz <= CSZ_RST;
      st_r.prr <= PRR_RST;
      st_r.udre <= 1'b1;
      st_r.txd <= 1'b1;
      st_r.rx_prev <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_dat_o = {24'h000000, st_r.rdat};
  assign wb_ack_o = st_r.ack;
  assign txd_o = st_r.txd;
  assign txd_oe_o = st_r.txoe;

  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------
  chk_baud_reload: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (st_r.cnt == 12'h000 && !wr) |=> st_r.cnt == $past(st_r.div))
    else $error("baud counter missed reload");
  chk_tick_rate: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (st_r.cnt != 12'h000) |=> !st_r.tick)
    else $error("tick without zero count");
  chk_bit_length: assert property (
    @(posedge clk_i) disable iff (rst_i)
    st_r.tx_sub <= last)
    else $error("transmit bit too long");
  chk_start_low: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (st_r.tx_st == TX_START) |-> !txd_o)
    else $error("start bit not low");
  chk_idle_high: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (st_r.tx_st == TX_IDLE) |-> txd_o)
    else $error("idle line not high");
  chk_empty_clear: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr && wb_adr_i == ADR_DATA) |=> !st_r.udre)
    else $error("buffer empty not cleared");
  chk_txc_set: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (tx_end && st_r.udre) |=> st_r.txc && st_r.tx_st == TX_IDLE)
    else $error("transmit complete not set");
  chk_pin_hold: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (st_r.tx_st != TX_IDLE || !st_r.udre) |-> txd_oe_o)
    else $error("pin released early");
  chk_false_start: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rx_dec && st_r.rx_st == RX_START && maj) |=>
      st_r.rx_st == RX_IDLE)
    else $error("false start accepted");
  chk_overrun_flag: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rx_push && st_r.rx_cnt == 2'h2 && !pop) |=>
      st_r.dor && st_r.rx_cnt == 2'h2)
    else $error("overrun not flagged");
  chk_ack_pulse: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (acc && !st_r.ack) |=> st_r.ack ##1 !st_r.ack)
    else $error("bus answer not one cycle");
endmodule // uart_baud_frame_core
`default_nettype wire

// [logic/uart_pkg.sv]
// Package: register map, field positions, reset values, state types.
// Assumes a 32-bit classic Wishbone slave; registers in byte lane 0.
package uart_pkg;
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADR_DATA = 8'h00; // tx_rx_data_buffer
  localparam logic [7:0] ADR_CSA = 8'h04; // ctrl_status_a
  localparam logic [7:0] ADR_CSB = 8'h08; // ctrl_status_b
  localparam logic [7:0] ADR_CSC = 8'h0c; // ctrl_status_c
  localparam logic [7:0] ADR_BDL = 8'h10; // baud_divisor_low
  localparam logic [7:0] ADR_BDH = 8'h14; // baud_divisor_high
  localparam logic [7:0] ADR_PRR = 8'h18; // power_reduction_reg
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CSA_RXC = 7; // rx_complete_flag
  localparam int CSA_TXC = 6; // tx_complete_flag
  localparam int CSA_UDRE = 5; // tx_buffer_empty_flag
  localparam int CSA_FERR = 4; // frame_error_flag
  localparam int CSA_DOR = 3; // Data overrun
  localparam int CSA_PERR = 2; // Parity error
  localparam int CSA_U2X = 1; // double_speed_select
  localparam int CSB_RXEN = 4; // Receiver enable
  localparam int CSB_TRANSMITTER_ENABLE_BIT = 3; // transmitter_enable_bit
  localparam int CSB_CSZ2 = 2; // char_size_field bit 2
  localparam int CSB_RX9 = 1; // Received ninth bit
  localparam int CSB_TX9 = 0; // Ninth bit to send
  localparam int CSC_PM = 4; // parity_mode_field, 2 bits
  localparam int CSC_STOP = 3; // stop_bit_select
  localparam int CSC_CSZ = 1; // char_size_field bits 1:0
  localparam int PRR_BIT = 0; // serial_power_reduce_bit
  // ---------------------------------------------------------------
  // Reset values and sample counts
  // ---------------------------------------------------------------
  localparam logic PRR_RST = 1'b1; // Block held off until cleared
  localparam logic [2:0] CSZ_RST = 3'h3; // Eight data bits
  localparam logic [2:0] CSZ_NINE = 3'h7; // Nine data bits code
  localparam logic [4:0] OVS_NORM = 5'h10; // Ticks per bit, normal
  localparam logic [4:0] OVS_DBL = 5'h08; // Ticks per bit, double
  // ---------------------------------------------------------------
  // State types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR,
    TX_STOP} tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR,
    RX_STOP} rx_state_t;
endpackage

// [bench/serial_node_model.sv]
// Remote serial node: decodes frames seen on txd, sends frames on rxd.
// Assumes the bench sets the bit length in clocks and the frame bit count.
`timescale 1ns/1ps
`default_nettype none
module serial_node_model (
  input wire logic clk_i,
  input wire logic txd_i,
  input wire logic txd_oe_i,
  input wire logic [15:0] bit_clks_i,
  input wire logic [3:0] frame_bits_i,
  output logic rxd_o
);
  // ---------------------------------------------------------------
  // Capture of frames from the block
  // ---------------------------------------------------------------
  logic [11:0] cap_q[$]; // Bits after start, first bit in bit 0
  int start_q[$]; // Clock count at each start edge
  int cyc_cnt = 0; // Free running clock count
  logic [11:0] w; // Frame being captured
  always @(posedge clk_i) cyc_cnt <= cyc_cnt + 1;
  initial rxd_o = 1'b1; // Line idles at the pull-up level
  // Start edge, then one sample in the middle of every bit
  initial forever begin
    @(negedge txd_i);
    if (txd_oe_i === 1'b1) begin
      start_q.push_back(cyc_cnt);
      repeat (bit_clks_i / 2) @(posedge clk_i);
      w = '1;
      for (int i = 0; i < frame_bits_i; i++) begin
        repeat (bit_clks_i) @(posedge clk_i);
        w[i] = txd_i;
      end
      cap_q.push_back(w);
    end
  end
  // ---------------------------------------------------------------
  // Sender: low start for len clocks, n bits LSB first, then idle
  // ---------------------------------------------------------------
  task automatic send(input logic [11:0] word, input int n, input int len);
    @(posedge clk_i);
    rxd_o <= 1'b0;
    repeat (len) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      rxd_o <= word[i];
      repeat (bit_clks_i) @(posedge clk_i);
    end
    rxd_o <= 1'b1;
  endtask
endmodule // serial_node_model
`default_nettype wire

// [bench/uart_baud_frame_core_test.sv]
// Testbench: register bus master, serial node, frame and flag checks.
// Assumes divisor 1, so one bit lasts 32 clocks, or 16 at double speed.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, exp, got) begin comparisons++; \
  if ((got) !== (exp)) begin fails++; \
  $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module uart_baud_frame_core_test;
  import uart_pkg::*;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic rxd_i, txd_o, txd_oe_o, u2x;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [15:0] bit_clks;
  logic [3:0] frame_bits;
  int fails = 0;
  int comparisons = 0;
  uart_baud_frame_core i_dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rxd_i(rxd_i),
    .txd_o(txd_o), .txd_oe_o(txd_oe_o));
  serial_node_model m (.clk_i(clk_i), .txd_i(txd_o), .txd_oe_i(txd_oe_o),
    .bit_clks_i(bit_clks), .frame_bits_i(frame_bits), .rxd_o(rxd_i));
  // ---------------------------------------------------------------
  // Bus and wait helpers
  // ---------------------------------------------------------------
  task automatic final_report();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // One classic cycle; read data lands in q
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    wb_sel_i <= 4'hf;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n == 20) begin
      fails++;
      $display("ERROR ack expected 1 seen 0");
      final_report();
    end
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 8'h00);
  endtask
  // Polls a register bit until set, bounded
  task automatic wait_bit(input logic [7:0] a, input int b);
    int n;
    for (n = 0; n < 400; n++) begin
      rd(a);
      if (q[b] === 1'b1) break;
    end
    `CHECK("status bit", 1'b1, q[b])
    if (n == 400) final_report();
  endtask
  // Waits until the node has captured k frames, bounded
  task automatic wait_cap(input int k);
    int n;
    for (n = 0; n < 3000 && m.cap_q.size() < k; n++) @(posedge clk_i);
    `CHECK("frames seen", k, m.cap_q.size())
    if (n == 3000) final_report();
  endtask
  // Expected bits after start: data LSB first, parity, stops high
  function automatic logic [11:0] fw(logic [8:0] d, int nb, logic [1:0] pm);
    logic [11:0] w;
    logic p;
    w = 12'hfff;
    p = pm[0];
    for (int i = 0; i < nb; i++) begin
      w[i] = d[i];
      p ^= d[i];
    end
    if (pm[1]) w[nb] = p;
    return w;
  endfunction
  // ---------------------------------------------------------------
  // One frame each way in the given format
  // ---------------------------------------------------------------
  task automatic one_frame(input logic [8:0] d, input logic [2:0] code,
    input logic [1:0] pm, input logic st);
    int nb;
    int nf;
    logic [11:0] w;
    logic [11:0] c;
    logic [7:0] m8;
    nb = (code == 3'h7) ? 9 : code + 5;
    nf = nb + pm[1] + 1 + st;
    m8 = (nb > 8) ? 8'hff : 8'hff >> (8 - nb);
    w = fw(d, nb, pm);
    frame_bits = nf[3:0];
    wr(ADR_CSC, {2'h0, pm, st, code[1:0], 1'b0});
    wr(ADR_CSB, {3'h0, 2'h3, code[2], 1'b0, d[8]});
    wr(ADR_CSA, {1'b0, 1'b1, 4'h0, u2x, 1'b0});
    wr(ADR_DATA, d[7:0]);
    wait_cap(1);
    c = m.cap_q.pop_front();
    `CHECK("tx frame", w, c)
    wait_bit(ADR_CSA, CSA_TXC);
    m.send(w, nf, bit_clks);
    wait_bit(ADR_CSA, CSA_RXC);
    `CHECK("rx flags", 3'h0, {q[CSA_FERR], q[CSA_DOR], q[CSA_PERR]})
    rd(ADR_CSB);
    if (nb == 9) `CHECK("rx ninth", d[8], q[CSB_RX9])
    rd(ADR_DATA);
    `CHECK("rx data", d[7:0] & m8, q[7:0] & m8)
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    `CHECK("txd idle", 1'b1, txd_o)
    `CHECK("txd oe", 1'b0, txd_oe_o)
    rd(ADR_PRR);
    `CHECK("power reduce", 8'h01, q[7:0])
    rd(ADR_CSA);
    `CHECK("status a", 8'h20, q[7:0])
    rd(ADR_CSC);
    `CHECK("status c", 8'h06, q[7:0])
    wr(8'h1c, 8'hff);
    rd(8'h1c);
    `CHECK("unmapped", 32'h0, q)
    wr(ADR_PRR, 8'h00);
    wr(ADR_BDH, 8'h00);
    wr(ADR_BDL, 8'h01);
    $display("test reset done");
  endtask
  task automatic t_formats();
    logic [2:0] codes[5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
    logic [1:0] pms[3] = '{2'h0, 2'h2, 2'h3};
    logic [8:0] d;
    d = 9'h0b5;
    foreach (codes[i]) begin
      foreach (pms[j]) begin
        for (int s = 0; s < 2; s++) begin
          one_frame(d, codes[i], pms[j], s[0]);
          d = {d[7:0], d[8] ^ d[4]};
        end
      end
    end
    $display("test formats done");
  endtask
  // Two frames back to back, transmitter switched off meanwhile
  task automatic t_b2b();
    int n;
    frame_bits = 4'd9;
    wr(ADR_CSC, 8'h06);
    wr(ADR_CSB, 8'h18);
    wr(ADR_CSA, 8'h40);
    m.start_q.delete();
    // Low byte write reloads the counter; one idle clock puts the ticks
    // in phase with the shifter load, so the first start bit is whole
    wr(ADR_BDL, 8'h01);
    @(posedge clk_i);
    wr(ADR_DATA, 8'h3c);
    wait_bit(ADR_CSA, CSA_UDRE);
    wr(ADR_DATA, 8'hc3);
    rd(ADR_CSA);
    `CHECK("buffer empty", 2'h0, {q[CSA_UDRE], q[CSA_TXC]})
    wr(ADR_CSB, 8'h10);
    `CHECK("oe held", 1'b1, txd_oe_o)
    wait_cap(2);
    `CHECK("spacing", 10 * 32, m.start_q[1] - m.start_q[0])
    `CHECK("first", fw(9'h03c, 8, 2'h0), m.cap_q[0])
    `CHECK("second", fw(9'h0c3, 8, 2'h0), m.cap_q[1])
    m.cap_q.delete();
    for (n = 0; n < 2000 && txd_oe_o !== 1'b0; n++) @(posedge clk_i);
    `CHECK("oe released", 2'h1, {txd_oe_o, txd_o})
    if (n == 2000) final_report();
    $display("test back to back done");
  endtask
  task automatic t_double();
    u2x = 1'b1;
    bit_clks = 16'd16;
    wr(ADR_CSA, 8'h02);
    one_frame(9'h0c3, 3'h3, 2'h3, 1'b1);
    u2x = 1'b0;
    bit_clks = 16'd32;
    wr(ADR_CSA, 8'h00);
    $display("test double speed done");
  endtask
  task automatic t_rxerr();
    logic [11:0] w;
    wr(ADR_CSC, 8'h26);
    wr(ADR_CSB, 8'h18);
    w = fw(9'h05a, 8, 2'h2);
    w[8] = ~w[8];
    m.send(w, 10, 32);
    wait_bit(ADR_CSA, CSA_RXC);
    `CHECK("parity error", 2'h1, {q[CSA_FERR], q[CSA_PERR]})
    rd(ADR_DATA);
    w = fw(9'h0a5, 8, 2'h2);
    w[9] = 1'b0;
    m.send(w, 10, 32);
    wait_bit(ADR_CSA, CSA_RXC);
    `CHECK("frame error", 1'b1, q[CSA_FERR])
    rd(ADR_DATA);
    wr(ADR_CSC, 8'h06);
    m.send(fw(9'h011, 8, 2'h0), 9, 32);
    m.send(fw(9'h022, 8, 2'h0), 9, 32);
    m.send(fw(9'h033, 8, 2'h0), 9, 32);
    rd(ADR_CSA);
    `CHECK("overrun", 1'b1, q[CSA_DOR])
    rd(ADR_DATA);
    `CHECK("rx head", 8'h11, q[7:0])
    rd(ADR_DATA);
    `CHECK("rx next", 8'h22, q[7:0])
    m.send(12'hfff, 0, 4);
    repeat (200) @(posedge clk_i);
    rd(ADR_CSA);
    `CHECK("no false start", 2'h0, {q[CSA_RXC], q[CSA_DOR]})
    $display("test rx errors done");
  endtask
  // ---------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  initial begin
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    u2x = 1'b0;
    bit_clks = 16'd32;
    frame_bits = 4'd9;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_formats();
    t_b2b();
    t_double();
    t_rxerr();
    final_report();
  end
  initial begin
    repeat (100000) @(posedge clk_i);
    fails++;
    $display("ERROR watchdog expected done seen running");
    final_report();
  end
endmodule // uart_baud_frame_core_test
`default_nettype wire
